// *** logic/sensor_reset_defines.svh ***
// Offsets, field positions, reset values and timing counts of the reset controller
`ifndef SENSOR_RESET_DEFINES_SVH
`define SENSOR_RESET_DEFINES_SVH

`define SYS_CTRL_OFFSET   16'h001A
`define SOFT_RESET_BIT    0
`define STREAM_GO_BIT     1
`define STREAMING_BIT     2
`define BOOTING_BIT       3
`define SYS_CTRL_RESET    16'h0000
`define CLK_PERIOD_NS     100
`define BOOT_TIME_MS      35
`define BOOT_CYCLES       ((`BOOT_TIME_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// *** logic/sensor_reset_pkg.sv ***
// Types shared by the reset and shutdown controller
package sensor_reset_pkg;

   // Gray coded along off -> reset -> boot -> stream -> suspend
   typedef enum logic [2:0] {
      ST_OFF     = 3'h4,
      ST_RESET   = 3'h0,
      ST_BOOT    = 3'h1,
      ST_STREAM  = 3'h3,
      ST_SUSPEND = 3'h2
   } ctrl_state_t;

endpackage

// *** logic/row_frame_timer.sv ***
// Progressive row and frame framing with horizontal and vertical blanking
module row_frame_timer #(
   parameter int unsigned ACTIVE_COLS = 1920,
   parameter int unsigned H_BLANK     = 16,
   parameter int unsigned ACTIVE_ROWS = 1080,
   parameter int unsigned V_BLANK     = 8,
   parameter int unsigned DATA_W      = 8
) (
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic              run,
   output logic                   row_qual,
   output logic                   frame_qual,
   output logic                   pix_clk,
   output logic [DATA_W-1:0]      pix_data
);
   localparam int unsigned COLS = ACTIVE_COLS + H_BLANK;
   localparam int unsigned ROWS = ACTIVE_ROWS + V_BLANK;
   localparam int unsigned CW   = $clog2(COLS);
   localparam int unsigned RW   = $clog2(ROWS);

   logic [CW-1:0] col;
   logic [RW-1:0] row;

   // ****************************************
   // Raster counters, cleared when not running
   // ****************************************
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         col <= '0;
         row <= '0;
      end else if (!run) begin
         col <= '0;
         row <= '0;
      end else if (col == CW'(COLS - 1)) begin
         col <= '0;
         row <= (row == RW'(ROWS - 1)) ? '0 : row + RW'(1);
      end else begin
         col <= col + CW'(1);
      end
   end

   // ****************************************
   // Row qualifier and data only over valid pixels, frame qualifier over all active rows
   // ****************************************
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         row_qual   <= 1'b0;
         frame_qual <= 1'b0;
         pix_data   <= '0;
      end else begin
         row_qual   <= run && (col < CW'(ACTIVE_COLS)) && (row < RW'(ACTIVE_ROWS));
         frame_qual <= run && (row < RW'(ACTIVE_ROWS));
         pix_data   <= (run && (col < CW'(ACTIVE_COLS)) && (row < RW'(ACTIVE_ROWS))) ?
                       DATA_W'(col ^ CW'(row)) : '0;
      end
   end

   // Toggles every cycle while running, also through blanking; low otherwise
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pix_clk <= 1'b0;
      end else begin
         pix_clk <= run ? ~pix_clk : 1'b0;
      end
   end

endmodule

// *** logic/sensor_reset_shutdown_ctrl.sv ***
// Reset, boot and shutdown sequencing with output pin states and image framing
// Operation
// - High on the shutdown input requests power-down; low means normal operation.
// - Rows stream progressively with blanking; row qualifier high only on valid pixels.
// - An internal reset starts on power-up without external action.
// - Three reset sources: reset pin, soft reset bit, power-on reset.
// - Reset pin low puts the device in reset for as long as it stays low.
// - In reset, pixel bus, pixel clock and both qualifiers are high impedance.
// - In reset, every serial lane clock and data output, both polarities, is 0.
// - Boot after reset release completes within 35 ms.
// - Writing 1 to control bit 0 at 0x001A starts a reset like a hard reset.
// - During shutdown all state and register content is discarded.
// - Leaving shutdown performs a complete power-on reset before operation.
// - A floating reset pin reads deasserted through its pull-up.
// - After boot, strap high starts streaming; otherwise suspend and wait for host.
`include "sensor_reset_defines.svh"

module sensor_reset_shutdown_ctrl #(
   parameter int unsigned BOOT_CYCLES = `BOOT_CYCLES,
   parameter int unsigned ACTIVE_COLS = 1920,
   parameter int unsigned ACTIVE_ROWS = 1080,
   parameter int unsigned H_BLANK     = 16,
   parameter int unsigned V_BLANK     = 8
) (
   input  wire logic                        core_clk,
   input  wire logic                        rst,
   input  wire logic                        reset_pin_n,
   input  wire logic                        shutdown_pin,
   input  wire logic                        config_strap,
   input  wire logic                        reg_wr,
   input  wire logic [15:0]                 reg_addr,
   input  wire logic [15:0]                 reg_wdata,
   output logic      [15:0]                 reg_rdata,
   output logic      [7:0]                  pixel_data,
   output logic                             pixel_data_oe,
   output logic                             pixel_output_clock,
   output logic                             pixel_output_clock_oe,
   output logic                             row_pixel_qualifier,
   output logic                             row_pixel_qualifier_oe,
   output logic                             frame_qualifier,
   output logic                             frame_qualifier_oe,
   output logic                             lane_clk_pos,
   output logic                             lane_clk_neg,
   output logic                             lane1_pos,
   output logic                             lane1_neg,
   output logic                             lane2_pos,
   output logic                             lane2_neg,
   output sensor_reset_pkg::ctrl_state_t    ctrl_state
);
   import sensor_reset_pkg::*;

   localparam int unsigned BW = $clog2(BOOT_CYCLES + 1);

   logic        por_ff1;
   logic        por_ff2;
   logic        pin_ff1;
   logic        pin_ff2;
   logic        sd_ff1;
   logic        sd_ff2;
   logic        strap_ff1;
   logic        strap_ff2;
   logic [15:0] system_control_reg;
   logic        strap_latched;
   logic [BW-1:0] boot_cnt;
   ctrl_state_t state;
   ctrl_state_t next_state;
   logic        hold_reset;
   logic        drive_pins;
   logic        lanes_idle;
   logic        fr_row;
   logic        fr_frame;
   logic        fr_clk;
   logic [7:0]  fr_data;

   // ****************************************
   // Reset release and pin synchronisers
   // ****************************************
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         por_ff1 <= 1'b1;
         por_ff2 <= 1'b1;
      end else begin
         por_ff1 <= 1'b0;
         por_ff2 <= por_ff1;
      end
   end

   always_ff @(posedge core_clk or posedge por_ff2) begin
      if (por_ff2) begin
         pin_ff1   <= 1'b1;
         pin_ff2   <= 1'b1;
         sd_ff1    <= 1'b0;
         sd_ff2    <= 1'b0;
      end else begin
         pin_ff1   <= reset_pin_n;
         pin_ff2   <= pin_ff1;
         sd_ff1    <= shutdown_pin;
         sd_ff2    <= sd_ff1;
      end
   end

   // No reset, so the strap is settled when power-on reset ends
   always_ff @(posedge core_clk) begin
      strap_ff1 <= config_strap;
      strap_ff2 <= strap_ff1;
   end

   // ****************************************
   // System control register
   // ****************************************
   function automatic logic hit(input logic [15:0] addr);
      return addr == `SYS_CTRL_OFFSET;
   endfunction

   always_ff @(posedge core_clk or posedge por_ff2) begin
      if (por_ff2) begin
         system_control_reg <= `SYS_CTRL_RESET;
      end else if (sd_ff2 || !pin_ff2) begin
         system_control_reg <= `SYS_CTRL_RESET;
      end else if (reg_wr && hit(reg_addr)) begin
         system_control_reg <= reg_wdata;
      end
   end

   always_comb begin
      reg_rdata = 16'h0000;
      if (hit(reg_addr)) begin
         reg_rdata                 = system_control_reg;
         reg_rdata[`STREAMING_BIT] = (state == ST_STREAM);
         reg_rdata[`BOOTING_BIT]   = (state == ST_BOOT);
      end
   end

   // ****************************************
   // Sequencer
   // ****************************************
   // Pull-up keeps an open pin high, so only por and the soft reset bit act then
   assign hold_reset = !pin_ff2 || system_control_reg[`SOFT_RESET_BIT];

   always_comb begin
      next_state = state;
      case (state)
         ST_OFF: begin
            next_state = sd_ff2 ? ST_OFF : ST_RESET;
         end
         ST_RESET: begin
            next_state = hold_reset ? ST_RESET : ST_BOOT;
         end
         ST_BOOT: begin
            if (boot_cnt == BW'(BOOT_CYCLES - 1)) begin
               next_state = strap_latched ? ST_STREAM : ST_SUSPEND;
            end
         end
         ST_STREAM: begin
            next_state = ST_STREAM;
         end
         ST_SUSPEND: begin
            if (system_control_reg[`STREAM_GO_BIT]) begin
               next_state = ST_STREAM;
            end
         end
         default: begin
            next_state = ST_RESET;
         end
      endcase
      if (hold_reset && state != ST_OFF) begin
         next_state = ST_RESET;
      end
      if (sd_ff2) begin
         next_state = ST_OFF;
      end
   end

   always_ff @(posedge core_clk or posedge por_ff2) begin
      if (por_ff2) begin
         state <= ST_RESET;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge core_clk or posedge por_ff2) begin
      if (por_ff2) begin
         boot_cnt <= '0;
      end else if (state == ST_BOOT) begin
         boot_cnt <= boot_cnt + BW'(1);
      end else begin
         boot_cnt <= '0;
      end
   end

   // Strap caught on every reset release, after the async reset
   always_ff @(posedge core_clk or posedge por_ff2) begin
      if (por_ff2) begin
         strap_latched <= 1'b0;
      end else if (state == ST_RESET) begin
         strap_latched <= strap_ff2;
      end
   end

   // ****************************************
   // Framing and output pin states
   // ****************************************
   row_frame_timer #(
      .ACTIVE_COLS (ACTIVE_COLS),
      .H_BLANK     (H_BLANK),
      .ACTIVE_ROWS (ACTIVE_ROWS),
      .V_BLANK     (V_BLANK),
      .DATA_W      (8)
   ) u_frame (
      .core_clk   (core_clk),
      .rst        (por_ff2),
      .run        (state == ST_STREAM),
      .row_qual   (fr_row),
      .frame_qual (fr_frame),
      .pix_clk    (fr_clk),
      .pix_data   (fr_data)
   );

   assign drive_pins             = (state == ST_STREAM) || (state == ST_SUSPEND);
   assign pixel_data             = fr_data;
   assign pixel_output_clock     = fr_clk;
   assign row_pixel_qualifier    = fr_row && (state == ST_STREAM);
   assign frame_qualifier        = fr_frame && (state == ST_STREAM);
   assign pixel_data_oe          = drive_pins;
   assign pixel_output_clock_oe  = drive_pins;
   assign row_pixel_qualifier_oe = drive_pins;
   assign frame_qualifier_oe     = drive_pins;

   // Stop state while streaming, low power zero otherwise
   assign lanes_idle   = (state == ST_STREAM);
   assign lane_clk_pos = lanes_idle;
   assign lane_clk_neg = lanes_idle;
   assign lane1_pos    = lanes_idle;
   assign lane1_neg    = lanes_idle;
   assign lane2_pos    = lanes_idle;
   assign lane2_neg    = lanes_idle;
   assign ctrl_state   = state;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (por_ff2);

   a_pin_holds_reset: assert property (!pin_ff2 |=> state inside {ST_RESET, ST_OFF})
      else $error("reset pin low but device left reset");
   a_soft_reset: assert property (system_control_reg[0] && !sd_ff2 |=> state == ST_RESET)
      else $error("soft reset bit did not reset sequencer");
   a_reset_hiz: assert property (state inside {ST_RESET, ST_OFF, ST_BOOT} |->
      !pixel_data_oe && !pixel_output_clock_oe && !row_pixel_qualifier_oe && !frame_qualifier_oe)
      else $error("parallel outputs driven during reset");
   a_reset_lanes_zero: assert property (state != ST_STREAM |->
      {lane_clk_pos, lane_clk_neg, lane1_pos, lane1_neg, lane2_pos, lane2_neg} == 6'h00)
      else $error("serial lanes not zero outside streaming");
   a_shutdown_enter: assert property ($rose(sd_ff2) |=> state == ST_OFF)
      else $error("shutdown request not honoured");
   a_shutdown_clear: assert property (state == ST_OFF |-> system_control_reg == 16'h0000)
      else $error("register content kept in shutdown");
   a_shutdown_por: assert property (state == ST_OFF && !sd_ff2 |=> state == ST_RESET)
      else $error("shutdown release skipped power-on reset");
   a_boot_bound: assert property (state == ST_BOOT |-> boot_cnt < BW'(BOOT_CYCLES))
      else $error("boot exceeded its time");
   a_boot_strap: assert property (state == ST_BOOT && next_state != ST_BOOT && !hold_reset && !sd_ff2
      |=> state == (strap_latched ? ST_STREAM : ST_SUSPEND))
      else $error("boot exit ignored strap");
   a_row_in_frame: assert property (row_pixel_qualifier |-> frame_qualifier && state == ST_STREAM)
      else $error("row qualifier outside frame");

   c_stream_entry: cover property (state == ST_BOOT ##1 state == ST_STREAM);
   c_suspend_entry: cover property (state == ST_BOOT ##1 state == ST_SUSPEND);
   c_soft_reset: cover property (state == ST_STREAM ##1 state == ST_RESET);
   c_shutdown_cycle: cover property (state == ST_OFF ##1 state == ST_RESET);

endmodule

// *** verification/host_model.sv ***
// Host processor model driving reset pin, shutdown pin and register writes
module host_model (
   input  wire logic        core_clk,
   output wire logic        reset_pin_n,
   output wire logic        test_reset,
   output logic             shutdown_pin,
   output logic             reg_wr,
   output logic [15:0]      reg_addr,
   output logic [15:0]      reg_wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int MIN_LOW = 50;
   logic    pull_low;
   int      low_cnt;
   // Released pin floats; board pull-up gives high
   assign reset_pin_n = pull_low ? 1'b0 : 1'bz;
   assign test_reset = 1'b0;
   initial begin
      pull_low = 1'b0;
      shutdown_pin = 1'b0;
      reg_wr = 1'b0;
      reg_addr = 16'h0000;
      reg_wdata = 16'h0000;
   end
   always @(posedge core_clk) begin
      low_cnt <= pull_low ? low_cnt + 1 : 0;
   end
   task assert_reset;
      @(posedge core_clk);
      pull_low <= 1'b1;
   endtask
   // Clock keeps running while low; release only after the minimum width
   task release_reset;
      @(posedge core_clk);
      while (low_cnt < MIN_LOW) @(posedge core_clk);
      pull_low <= 1'b0;
   endtask
   task write_reg(input logic [15:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task set_addr(input logic [15:0] a);
      @(posedge core_clk);
      reg_addr <= a;
   endtask
   task set_shutdown(input logic v);
      @(posedge core_clk);
      shutdown_pin <= v;
   endtask
endmodule

// *** verification/tb_sensor_reset_shutdown_ctrl.sv ***
// Self-checking testbench of the reset and shutdown controller
`define CHK(nm, exp, got) begin \
   n_checks++; \
   if ((got) !== (exp)) begin \
      fails++; \
      $display("Error %s expected %h seen %h", nm, (exp), (got)); \
   end \
end
module tb_sensor_reset_shutdown_ctrl;
   timeunit 1ns;
   timeprecision 1ns;
   import sensor_reset_pkg::*;
   localparam int BOOT = 20;
   localparam int COLS = 8;
   localparam int ROWS = 4;
   localparam int HB   = 4;
   localparam int VB   = 2;
   localparam int LIMIT = 5000;
   logic          core_clk, rst, config_strap, shutdown_pin, reg_wr;
   wire           reset_pin_n, test_reset;
   logic [15:0]   reg_addr, reg_wdata, reg_rdata;
   logic [7:0]    pixel_data;
   logic          pixel_data_oe, pixel_output_clock, pixel_output_clock_oe;
   logic          row_pixel_qualifier, row_pixel_qualifier_oe, frame_qualifier, frame_qualifier_oe;
   logic          lane_clk_pos, lane_clk_neg, lane1_pos, lane1_neg, lane2_pos, lane2_neg;
   ctrl_state_t   ctrl_state;
   int            fails, n_checks, cycles;
   pullup (reset_pin_n);
   sensor_reset_shutdown_ctrl #(.BOOT_CYCLES(BOOT), .ACTIVE_COLS(COLS), .ACTIVE_ROWS(ROWS), .H_BLANK(HB),
      .V_BLANK(VB)) sensor_reset_shutdown_ctrl_inst (
      .core_clk(core_clk), .rst(rst), .reset_pin_n(reset_pin_n), .shutdown_pin(shutdown_pin),
      .config_strap(config_strap), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .pixel_data(pixel_data), .pixel_data_oe(pixel_data_oe),
      .pixel_output_clock(pixel_output_clock), .pixel_output_clock_oe(pixel_output_clock_oe),
      .row_pixel_qualifier(row_pixel_qualifier), .row_pixel_qualifier_oe(row_pixel_qualifier_oe),
      .frame_qualifier(frame_qualifier), .frame_qualifier_oe(frame_qualifier_oe),
      .lane_clk_pos(lane_clk_pos), .lane_clk_neg(lane_clk_neg), .lane1_pos(lane1_pos),
      .lane1_neg(lane1_neg), .lane2_pos(lane2_pos), .lane2_neg(lane2_neg), .ctrl_state(ctrl_state));
   host_model host_model_inst (
      .core_clk(core_clk), .reset_pin_n(reset_pin_n), .test_reset(test_reset),
      .shutdown_pin(shutdown_pin), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task close_out;
      if (fails == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         fails++;
         close_out();
      end
   end
   task pins_are(input logic [3:0] oe, input logic [5:0] lanes);
      `CHK("oe", oe, {pixel_data_oe, pixel_output_clock_oe, row_pixel_qualifier_oe, frame_qualifier_oe})
      `CHK("lanes", lanes, {lane_clk_pos, lane_clk_neg, lane1_pos, lane1_neg, lane2_pos, lane2_neg})
   endtask
   task wait_state(input ctrl_state_t st, input int lim);
      int i;
      for (i = 0; i < lim && ctrl_state !== st; i++) @(negedge core_clk);
      `CHK("state", st, ctrl_state)
   endtask
   task boot_to(input ctrl_state_t st);
      int n;
      wait_state(ST_BOOT, 12);
      n = 0;
      while (ctrl_state === ST_BOOT && n < BOOT + 8) begin
         @(negedge core_clk);
         n++;
      end
      `CHK("boot_len", 1'b1, (n >= BOOT - 1 && n <= BOOT + 1))
      `CHK("after_boot", st, ctrl_state)
   endtask
   task t_power_on;
      @(negedge core_clk);
      `CHK("por_state", ST_RESET, ctrl_state)
      pins_are(4'h0, 6'h00);
      @(posedge core_clk);
      rst <= 1'b0;
      boot_to(ST_STREAM);
      pins_are(4'hF, 6'h3F);
      host_model_inst.set_addr(16'h001A);
      @(negedge core_clk);
      `CHK("ctrl_rst_val", 16'h0004, reg_rdata)
      host_model_inst.set_addr(16'h001C);
      @(negedge core_clk);
      `CHK("unmapped", 16'h0000, reg_rdata)
   endtask
   task t_frame;
      int rq, fq, bad, tog;
      logic prev;
      rq = 0;
      fq = 0;
      bad = 0;
      tog = 0;
      prev = pixel_output_clock;
      repeat ((COLS + HB) * (ROWS + VB)) begin
         @(negedge core_clk);
         if (row_pixel_qualifier === 1'b1) rq++;
         if (frame_qualifier === 1'b1) fq++;
         if (row_pixel_qualifier === 1'b1 && frame_qualifier !== 1'b1) bad++;
         if (row_pixel_qualifier !== 1'b1 && pixel_data !== 8'h00) bad++;
         if (pixel_output_clock !== prev) tog++;
         prev = pixel_output_clock;
      end
      `CHK("valid_pixels", COLS * ROWS, rq)
      `CHK("frame_rows", (COLS + HB) * ROWS, fq)
      `CHK("row_outside_frame", 0, bad)
      `CHK("pix_clk_toggles", (COLS + HB) * (ROWS + VB), tog)
   endtask
   task t_hard;
      host_model_inst.assert_reset();
      repeat (4) @(negedge core_clk);
      `CHK("hard_state", ST_RESET, ctrl_state)
      pins_are(4'h0, 6'h00);
      repeat (30) @(negedge core_clk);
      `CHK("hard_hold", ST_RESET, ctrl_state)
      host_model_inst.release_reset();
      boot_to(ST_STREAM);
   endtask
   task t_soft;
      @(posedge core_clk);
      config_strap <= 1'b0;
      host_model_inst.write_reg(16'h001A, 16'h0001);
      wait_state(ST_RESET, 4);
      pins_are(4'h0, 6'h00);
      host_model_inst.write_reg(16'h001A, 16'h0000);
      boot_to(ST_SUSPEND);
      pins_are(4'hF, 6'h00);
      host_model_inst.write_reg(16'h001A, 16'h0002);
      wait_state(ST_STREAM, 6);
      @(posedge core_clk);
      config_strap <= 1'b1;
   endtask
   task t_shutdown;
      host_model_inst.write_reg(16'h001A, 16'h0010);
      host_model_inst.set_addr(16'h001A);
      @(negedge core_clk);
      `CHK("stored_bit", 16'h0010, reg_rdata & 16'h0010)
      host_model_inst.set_shutdown(1'b1);
      wait_state(ST_OFF, 6);
      pins_are(4'h0, 6'h00);
      `CHK("off_reg", 16'h0000, reg_rdata & 16'hFFF3)
      host_model_inst.write_reg(16'h001A, 16'h0010);
      @(negedge core_clk);
      `CHK("off_write", 16'h0000, reg_rdata & 16'h0010)
      host_model_inst.set_shutdown(1'b0);
      wait_state(ST_RESET, 6);
      boot_to(ST_STREAM);
   endtask
   initial begin
      rst = 1'b1;
      config_strap = 1'b1;
      fails = 0;
      n_checks = 0;
      cycles = 0;
      repeat (15) @(posedge core_clk);
      t_power_on();
      t_frame();
      t_hard();
      t_soft();
      t_shutdown();
      close_out();
   end
endmodule
